//--- pci_bridge_regs.svh
// Functional notes
// - Sample FRAME, IRDY, TRDY on rising edges only
// - Address phase under FRAME; data next edge
// - Word moves when IRDY and TRDY both low
// - Either side waits by holding ready high
// - No ending before current data phase completes
// - Bus idle when FRAME and IRDY high
// - Burst is address then 32-bit data phases
// - Master does single and burst reads, writes
// - Generate driven parity, check received parity (only master read data is checked)
// - Target cannot proceed raises retry to back end
// - Target fatal error raises target abort
// - No target answer ends access, master abort
// - Back end runs on the bus clock only
// - Master done pulses when access completes
// - Config read or write raises matching strobe
// - Four cycles without target forces retirement
// - Config access drops pending master request
// - Sustained tri-state driven high before floating
//
// Purpose: constants of the bus bridge
// Assumes: active-low bus pins, one clock
// Notes: definitions only
`ifndef PCI_BRIDGE_REGS_SVH
`define PCI_BRIDGE_REGS_SVH

// Bus commands
`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
// Upper three command bits shared by config read and write
`define CMD_CFG_HI 3'h5
// All byte lanes enabled (active low)
`define BE_ALL 4'h0
// Cycles without a target claim before master abort
`define DEVSEL_TIMEOUT 3'h4
`define WAIT_STEP 3'h1
`define WAIT_ZERO 3'h0
`define WORD_ZERO 32'h0

`endif

//--- pci_bridge_pkg.sv
// Purpose: shared types of the bus bridge
// Assumes: nothing
// Notes: sequencer states only
package pci_bridge_pkg;

  // Control sequencer states
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_DATA,
    S_PARK,
    S_CFG_CLAIM,
    S_CFG_WAIT,
    S_CFG_END
  } state_e;

endpackage

//--- parity_tree.sv
// Purpose: even parity over address/data and command lanes
// Assumes: purely combinational use
// Notes: used for both generation and checking
`timescale 1ns/1ps
module parity_tree (
  // Lanes to cover
  input wire logic [31:0] data,
  input wire logic [3:0] cmd,
  // Parity bit making the 37-bit total even
  output logic parity
);

  // Reduction over all lanes
  assign parity = ^{data, cmd};

endmodule

//--- pci_bridge.sv
// Purpose: bus master and config slave sequencer
// Assumes: back end on the bus clock, inputs same domain
// Notes: every output is a flip-flop
`timescale 1ns/1ps
`include "pci_bridge_regs.svh"
module pci_bridge
  import pci_bridge_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Bus control pins
  input wire logic FRAME_N_I,
  output logic FRAME_N_O,
  output logic FRAME_N_OE,
  input wire logic IRDY_N_I,
  output logic IRDY_N_O,
  output logic IRDY_N_OE,
  input wire logic TRDY_N_I,
  output logic TRDY_N_O,
  output logic TRDY_N_OE,
  input wire logic DEVSEL_N_I,
  output logic DEVSEL_N_O,
  output logic DEVSEL_N_OE,
  input wire logic STOP_N_I,
  input wire logic IDSEL,
  input wire logic GNT_N,
  output logic REQ_N,
  // Bus address, data and parity pins
  input wire logic [31:0] AD_I,
  output logic [31:0] AD_O,
  output logic AD_OE,
  input wire logic [3:0] CBE_I,
  output logic [3:0] CBE_O,
  output logic CBE_OE,
  input wire logic PAR_I,
  output logic PAR_O,
  output logic PAR_OE,
  // Back-end master request
  input wire logic BACKEND_MASTER_REQUEST,
  input wire logic WRITE_SEL,
  input wire logic IO_SEL,
  input wire logic BURST_IN,
  input wire logic [31:0] MASTER_ADDR,
  input wire logic [31:0] MASTER_WDATA,
  // Back-end master answer
  output logic MASTER_NEXT,
  output logic [31:0] MASTER_RDATA,
  output logic BACKEND_MASTER_DONE,
  output logic RETRY_OUT,
  output logic TARGET_ABORT,
  output logic MASTER_ABORT,
  output logic PARITY_ERROR,
  // Back-end config slave
  output logic CFG_READ_STROBE,
  output logic CFG_WRITE_STROBE,
  input wire logic CFG_DONE_IN,
  input wire logic [31:0] CFG_RDATA,
  output logic [31:0] CFG_ADDR,
  output logic [31:0] CFG_WDATA
);

  state_e state_reg, state_next; // Sequencer state
  logic frame_reg, frame_next, frame_oe_reg, frame_oe_next;
  logic irdy_reg, irdy_next, irdy_oe_reg, irdy_oe_next;
  logic trdy_reg, trdy_next, trdy_oe_reg, trdy_oe_next;
  logic devsel_reg, devsel_next, devsel_oe_reg, devsel_oe_next;
  logic req_reg, req_next; // Bus request, active low
  logic [31:0] ad_reg, ad_next; // Driven address/data
  logic ad_oe_reg, ad_oe_next;
  logic [3:0] cbe_reg, cbe_next; // Driven command/enables
  logic cbe_oe_reg, cbe_oe_next;
  logic par_reg, par_next, par_oe_reg, par_oe_next;
  logic write_reg, write_next; // Latched direction
  logic seen_reg, seen_next; // Target has claimed
  logic [2:0] wait_reg, wait_next; // Cycles without claim
  logic done_reg, done_next, retry_reg, retry_next;
  logic tabort_reg, tabort_next, mabort_reg, mabort_next;
  logic next_reg, next_next; // Word taken pulse
  logic [31:0] rdata_reg, rdata_next;
  logic chk_reg, chk_next; // Received word awaits parity
  logic [31:0] rx_ad_reg, rx_ad_next; // Received word
  logic [3:0] rx_cbe_reg, rx_cbe_next;
  logic perr_reg, perr_next;
  logic cfg_rd_reg, cfg_rd_next, cfg_wr_reg, cfg_wr_next;
  logic [31:0] cfg_addr_reg, cfg_addr_next;
  logic [31:0] cfg_wdata_reg, cfg_wdata_next;
  logic gen_par; // Parity of what was driven last cycle
  logic rx_par; // Parity of what was received
  logic xfer; // Master data phase completes this edge

  // Parity of the lanes driven in the previous cycle
  parity_tree gen_tree (
    .data(ad_reg),
    .cmd(cbe_reg),
    .parity(gen_par)
  );

  // Parity of the word captured on the last transfer
  parity_tree chk_tree (
    .data(rx_ad_reg),
    .cmd(rx_cbe_reg),
    .parity(rx_par)
  );

  // Both ready lines low at this edge
  assign xfer = !irdy_reg && !TRDY_N_I;

  // Next-state and output computation
  always_comb
  begin
    state_next = state_reg;
    frame_next = frame_reg;
    frame_oe_next = frame_oe_reg;
    irdy_next = irdy_reg;
    irdy_oe_next = irdy_oe_reg;
    trdy_next = trdy_reg;
    trdy_oe_next = trdy_oe_reg;
    devsel_next = devsel_reg;
    devsel_oe_next = devsel_oe_reg;
    req_next = req_reg;
    ad_next = ad_reg;
    ad_oe_next = ad_oe_reg;
    cbe_next = cbe_reg;
    cbe_oe_next = cbe_oe_reg;
    write_next = write_reg;
    seen_next = seen_reg;
    wait_next = wait_reg;
    rdata_next = rdata_reg;
    rx_ad_next = rx_ad_reg;
    rx_cbe_next = rx_cbe_reg;
    cfg_rd_next = cfg_rd_reg;
    cfg_wr_next = cfg_wr_reg;
    cfg_addr_next = cfg_addr_reg;
    cfg_wdata_next = cfg_wdata_reg;
    done_next = 1'b0;
    retry_next = 1'b0;
    tabort_next = 1'b0;
    mabort_next = 1'b0;
    next_next = 1'b0;
    chk_next = 1'b0;
    // Parity follows the driven lanes one cycle later
    par_next = gen_par;
    par_oe_next = ad_oe_reg;
    // Compare received parity one cycle after the word
    perr_next = chk_reg && (rx_par != PAR_I);
    unique case (state_reg)
      S_IDLE:
      begin
        req_next = !BACKEND_MASTER_REQUEST;
        if (!FRAME_N_I && IDSEL && CBE_I[3:1] == `CMD_CFG_HI)
        begin
          // Config claim wins; master request waits
          state_next = S_CFG_CLAIM;
          req_next = 1'b1;
          write_next = CBE_I[0];
          cfg_addr_next = AD_I;
          devsel_next = 1'b0;
          devsel_oe_next = 1'b1;
          trdy_next = 1'b1;
          trdy_oe_next = 1'b1;
        end
        else if (BACKEND_MASTER_REQUEST && !req_reg && !GNT_N &&
                 FRAME_N_I && IRDY_N_I)
        begin
          // Address phase: FRAME, address and command
          state_next = S_ADDR;
          req_next = 1'b1;
          write_next = WRITE_SEL;
          seen_next = 1'b0;
          wait_next = `WAIT_ZERO;
          frame_next = 1'b0;
          frame_oe_next = 1'b1;
          irdy_next = 1'b1;
          irdy_oe_next = 1'b1;
          ad_next = MASTER_ADDR;
          ad_oe_next = 1'b1;
          cbe_oe_next = 1'b1;
          // Space and direction pick the command
          if (IO_SEL)
            cbe_next = WRITE_SEL ? `CMD_IO_WRITE : `CMD_IO_READ;
          else
            cbe_next = WRITE_SEL ? `CMD_MEM_WRITE : `CMD_MEM_READ;
        end
      end
      S_ADDR:
      begin
        // First data phase; FRAME stays only for a burst
        state_next = S_DATA;
        irdy_next = 1'b0;
        frame_next = !BURST_IN;
        cbe_next = `BE_ALL;
        ad_next = MASTER_WDATA;
        ad_oe_next = write_reg;
      end
      S_DATA:
      begin
        if (!DEVSEL_N_I)
          seen_next = 1'b1;
        else if (!seen_reg)
          wait_next = wait_reg + `WAIT_STEP;
        if (xfer)
        begin
          // Word moved; last phase or stop ends it
          next_next = 1'b1;
          if (!write_reg)
          begin
            rdata_next = AD_I;
            rx_ad_next = AD_I;
            rx_cbe_next = CBE_I;
            chk_next = 1'b1;
          end
          if (frame_reg || !STOP_N_I)
          begin
            state_next = S_PARK;
            done_next = 1'b1;
          end
          else
          begin
            // One wait so the back end can offer the next word
            irdy_next = 1'b1;
          end
        end
        else if (!STOP_N_I && !DEVSEL_N_I)
        begin
          // Stop without data: target cannot proceed now
          state_next = S_PARK;
          retry_next = 1'b1;
          done_next = 1'b1;
        end
        else if (!STOP_N_I && seen_reg)
        begin
          // Claim dropped with stop: fatal target error
          state_next = S_PARK;
          tabort_next = 1'b1;
          done_next = 1'b1;
        end
        else if (!seen_reg && wait_reg == `DEVSEL_TIMEOUT)
        begin
          // Nobody claimed; retire so the bus is not locked
          state_next = S_PARK;
          mabort_next = 1'b1;
          done_next = 1'b1;
        end
        else if (irdy_reg)
        begin
          // Wait over: next word out, FRAME follows burst
          irdy_next = 1'b0;
          ad_next = MASTER_WDATA;
          frame_next = !BURST_IN;
        end
        else
        begin
          // Keep IRDY low; FRAME may only rise
          frame_next = frame_reg || !BURST_IN;
        end
        if (state_next == S_PARK)
        begin
          // Drive lines high for one clock
          frame_next = 1'b1;
          irdy_next = 1'b1;
          ad_oe_next = 1'b0;
          cbe_oe_next = 1'b0;
        end
      end
      S_PARK:
      begin
        // Float after the high cycle
        state_next = S_IDLE;
        frame_oe_next = 1'b0;
        irdy_oe_next = 1'b0;
        trdy_oe_next = 1'b0;
        devsel_oe_next = 1'b0;
      end
      S_CFG_CLAIM:
      begin
        // Hand the access to the back end
        state_next = S_CFG_WAIT;
        cfg_rd_next = !write_reg;
        cfg_wr_next = write_reg;
      end
      S_CFG_WAIT:
      begin
        if (!IRDY_N_I && write_reg)
          cfg_wdata_next = AD_I;
        if (CFG_DONE_IN)
        begin
          // Back end finished; offer the data phase
          state_next = S_CFG_END;
          cfg_rd_next = 1'b0;
          cfg_wr_next = 1'b0;
          trdy_next = 1'b0;
          ad_next = CFG_RDATA;
          ad_oe_next = !write_reg;
        end
      end
      S_CFG_END:
      begin
        // Wait for the initiator's IRDY
        if (!IRDY_N_I)
        begin
          if (write_reg)
            cfg_wdata_next = AD_I;
          state_next = S_PARK;
          trdy_next = 1'b1;
          devsel_next = 1'b1;
          ad_oe_next = 1'b0;
        end
      end
    endcase
  end

  // Register all state; reset floats every tri-state pin, drives REQ_N high
  // Back end shares this clock
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_reg <= S_IDLE;
      {frame_reg, irdy_reg, trdy_reg, devsel_reg, req_reg} <= 5'h1f;
      {frame_oe_reg, irdy_oe_reg, trdy_oe_reg, devsel_oe_reg} <= 4'h0;
      {ad_oe_reg, cbe_oe_reg, par_reg, par_oe_reg} <= 4'h0;
      ad_reg <= `WORD_ZERO;
      cbe_reg <= `BE_ALL;
      {write_reg, seen_reg, done_reg, retry_reg} <= 4'h0;
      {tabort_reg, mabort_reg, next_reg, chk_reg} <= 4'h0;
      {perr_reg, cfg_rd_reg, cfg_wr_reg} <= 3'h0;
      wait_reg <= `WAIT_ZERO;
      rdata_reg <= `WORD_ZERO;
      rx_ad_reg <= `WORD_ZERO;
      rx_cbe_reg <= `BE_ALL;
      cfg_addr_reg <= `WORD_ZERO;
      cfg_wdata_reg <= `WORD_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      {frame_reg, irdy_reg, trdy_reg} <= {frame_next, irdy_next, trdy_next};
      {devsel_reg, req_reg} <= {devsel_next, req_next};
      {frame_oe_reg, irdy_oe_reg} <= {frame_oe_next, irdy_oe_next};
      {trdy_oe_reg, devsel_oe_reg} <= {trdy_oe_next, devsel_oe_next};
      {ad_oe_reg, cbe_oe_reg} <= {ad_oe_next, cbe_oe_next};
      {par_reg, par_oe_reg} <= {par_next, par_oe_next};
      ad_reg <= ad_next;
      cbe_reg <= cbe_next;
      {write_reg, seen_reg, done_reg} <= {write_next, seen_next, done_next};
      {retry_reg, tabort_reg} <= {retry_next, tabort_next};
      {mabort_reg, next_reg, chk_reg} <= {mabort_next, next_next, chk_next};
      {perr_reg, cfg_rd_reg, cfg_wr_reg} <= {perr_next, cfg_rd_next,
                                             cfg_wr_next};
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      rx_ad_reg <= rx_ad_next;
      rx_cbe_reg <= rx_cbe_next;
      cfg_addr_reg <= cfg_addr_next;
      cfg_wdata_reg <= cfg_wdata_next;
    end
  end

  // Ports straight from flip-flops
  assign {FRAME_N_O, FRAME_N_OE} = {frame_reg, frame_oe_reg};
  assign {IRDY_N_O, IRDY_N_OE} = {irdy_reg, irdy_oe_reg};
  assign {TRDY_N_O, TRDY_N_OE} = {trdy_reg, trdy_oe_reg};
  assign {DEVSEL_N_O, DEVSEL_N_OE} = {devsel_reg, devsel_oe_reg};
  assign REQ_N = req_reg;
  assign {AD_O, AD_OE, CBE_O, CBE_OE} = {ad_reg, ad_oe_reg, cbe_reg,
                                         cbe_oe_reg};
  assign {PAR_O, PAR_OE} = {par_reg, par_oe_reg};
  assign {MASTER_NEXT, MASTER_RDATA} = {next_reg, rdata_reg};
  assign {BACKEND_MASTER_DONE, RETRY_OUT} = {done_reg, retry_reg};
  assign {TARGET_ABORT, MASTER_ABORT} = {tabort_reg, mabort_reg};
  assign PARITY_ERROR = perr_reg;
  assign {CFG_READ_STROBE, CFG_WRITE_STROBE} = {cfg_rd_reg, cfg_wr_reg};
  assign {CFG_ADDR, CFG_WDATA} = {cfg_addr_reg, cfg_wdata_reg};

  // Checks on the sequencer
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  idle_floats_a: assert property (
    state_reg == S_IDLE |-> !frame_oe_reg && !irdy_oe_reg && !ad_oe_reg
      && !trdy_oe_reg && !devsel_oe_reg)
    else $error("bus pins driven while idle");
  park_high_a: assert property (
    $fell(frame_oe_reg) || $fell(irdy_oe_reg) |->
      $past(frame_reg) && $past(irdy_reg))
    else $error("control line floated without high cycle");
  data_phase_a: assert property (
    state_reg == S_ADDR |-> !frame_reg && frame_oe_reg ##1
      !irdy_reg && state_reg == S_DATA)
    else $error("data phase did not follow address phase");
  addr_parity_a: assert property (
    state_reg == S_ADDR |=> par_oe_reg && par_reg == ^{$past(ad_reg),
      $past(cbe_reg)})
    else $error("address parity wrong");
  last_done_a: assert property (
    state_reg == S_DATA && xfer && frame_reg |=>
      BACKEND_MASTER_DONE && state_reg == S_PARK)
    else $error("completed access not acknowledged");
  retry_flag_a: assert property (
    state_reg == S_DATA && !irdy_reg && TRDY_N_I && !STOP_N_I &&
      !DEVSEL_N_I |=> RETRY_OUT && BACKEND_MASTER_DONE)
    else $error("retry not reported");
  target_abort_a: assert property (
    state_reg == S_DATA && seen_reg && TRDY_N_I && !STOP_N_I &&
      DEVSEL_N_I |=> TARGET_ABORT)
    else $error("target abort not reported");
  master_abort_a: assert property (
    state_reg == S_ADDR ##1 DEVSEL_N_I [*5] |=> MASTER_ABORT)
    else $error("master abort not raised after four cycles");
  wait_hold_a: assert property (
    state_reg == S_DATA && TRDY_N_I && STOP_N_I && wait_reg <
      `DEVSEL_TIMEOUT |=> !irdy_reg)
    else $error("master left data phase early");
  cfg_strobe_a: assert property (
    state_reg == S_CFG_CLAIM && !write_reg |=> CFG_READ_STROBE
      until_with CFG_DONE_IN)
    else $error("config read strobe missing");
  burst_wait_a: assert property (
    state_reg == S_DATA && xfer && !frame_reg && STOP_N_I |=>
      irdy_reg && state_reg == S_DATA)
    else $error("burst wait cycle missing");

  cover property (state_reg == S_DATA && xfer && frame_reg && !write_reg);
  cover property (state_reg == S_DATA && xfer && !frame_reg);
  cover property (CFG_WRITE_STROBE && CFG_DONE_IN);
  cover property (MASTER_ABORT);

endmodule

//--- bus_target.sv
// Purpose: behavioural bus target facing the bridge master
// Assumes: one clock; released lines are pulled high outside
// Notes: mode 0 fast, 1 retry, 2 abort, 3 silent, 4 slow, 5 bad parity
`timescale 1ns/1ps
module bus_target (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Resolved bus lines and scenario mode
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic [2:0] mode,
  // Target drive
  output logic ctl_oe,
  output logic devsel_n,
  output logic trdy_n,
  output logic stop_n,
  output logic ad_oe,
  output logic [31:0] ad_o,
  output logic par_oe,
  output logic par_o
);
  localparam logic [31:0] RBASE = 32'h3c00_0000;
  logic act, fin, rd, idle_q; // Claimed, ending, read, bus idle
  logic [3:0] cyc; // Cycles since address phase
  logic [3:0] wt; // Cycles before ready
  logic [3:0] wcount; // Words moved
  logic [31:0] wlog [8]; // Words received
  logic xfer; // Word moves at this edge
  assign wt = {3'h0, rd} + ((mode == 3'h4) ? 4'h2 : 4'h0);
  assign xfer = ctl_oe && !trdy_n && !irdy_n;
  // Whole target side in one process
  always @(posedge clk)
  begin
    idle_q <= frame_n & irdy_n;
    par_o <= (^ad_o) ^ (mode == 3'h5);
    par_oe <= ad_oe;
    if (!rst_n)
    begin
      {act, fin, ctl_oe, ad_oe, par_oe} <= '0;
      {devsel_n, trdy_n, stop_n} <= 3'b111;
      wcount <= '0;
    end
    else if (fin)
      {act, fin, ctl_oe, ad_oe} <= '0;
    else if (!act)
    begin
      // Claim a non-config address phase after idle
      if (!frame_n && idle_q && cbe[3:1] != 3'h5)
      begin
        act <= 1'b1;
        cyc <= '0;
        rd <= !cbe[0];
        ad_o <= RBASE;
        wcount <= '0;
        ctl_oe <= (mode != 3'h3);
        devsel_n <= (mode == 3'h3);
        {trdy_n, stop_n} <= 2'b11;
      end
    end
    else
    begin
      cyc <= cyc + 4'h1;
      ad_oe <= rd && mode != 3'h3;
      if (xfer)
      begin
        wlog[wcount] <= ad;
        wcount <= wcount + 4'h1;
        ad_o <= ad_o + 32'h1;
      end
      // End only after last phase, stop or idle bus
      if (frame_n && (xfer || !stop_n || (mode == 3'h3 && irdy_n)))
      begin
        {devsel_n, trdy_n, stop_n} <= 3'b111;
        fin <= 1'b1;
      end
      else
      begin
        devsel_n <= (mode == 3'h2);
        stop_n <= !(mode == 3'h1 || mode == 3'h2);
        trdy_n <= mode inside {3'h1, 3'h2, 3'h3} || cyc < wt;
      end
    end
  end
endmodule

//--- testbench.sv
// Purpose: self-checking bench for the bus bridge
// Assumes: bench is arbiter, config initiator and back end
// Notes: wires resolve from every driver enable
`timescale 1ns/1ps
`include "pci_bridge_regs.svh"
module testbench;
  localparam logic [31:0] A = 32'h0000_1230; // Master address
  localparam logic [31:0] W = 32'h7700_0010; // First write word
  localparam logic [31:0] RB = 32'h3c00_0000; // Target read base
  localparam logic [31:0] CA = 32'h0000_0044; // Config address
  localparam logic [31:0] CD = 32'h1234_abcd; // Config word
  // Bench-driven inputs
  logic CLK = 0, RST_N = 0, GNT_N = 1, IDSEL = 0, CFG_DONE_IN = 0;
  logic BACKEND_MASTER_REQUEST = 0, WRITE_SEL = 0, IO_SEL = 0, BURST_IN = 0;
  logic [31:0] MASTER_ADDR = A, MASTER_WDATA = W, CFG_RDATA = 0;
  logic b_oe = 0, b_frame = 1, b_irdy = 1, b_ad_oe = 0; // Initiator
  logic [31:0] b_ad = 0, flt = 32'h5a5a_a5a5;
  logic [3:0] b_cbe = 0;
  logic [2:0] mode = 0;
  // Design outputs
  logic FRAME_N_O, FRAME_N_OE, IRDY_N_O, IRDY_N_OE, TRDY_N_O, TRDY_N_OE;
  logic DEVSEL_N_O, DEVSEL_N_OE, REQ_N, AD_OE, CBE_OE, PAR_O, PAR_OE;
  logic [31:0] AD_O, MASTER_RDATA, CFG_ADDR, CFG_WDATA;
  logic [3:0] CBE_O;
  logic MASTER_NEXT, BACKEND_MASTER_DONE, RETRY_OUT, TARGET_ABORT;
  logic MASTER_ABORT, PARITY_ERROR, CFG_READ_STROBE, CFG_WRITE_STROBE;
  // Target outputs and resolved wires
  logic t_oe, t_dev, t_trdy, t_stop, t_ad_oe, t_par_oe, t_par;
  logic [31:0] t_ad, ad_w;
  logic frame_w, irdy_w, trdy_w, devsel_w, stop_w, par_w;
  logic [3:0] cbe_w, poe, po;
  int bad_count = 0, total_checks = 0, xf = 0, mn = 1;
  assign frame_w = FRAME_N_OE ? FRAME_N_O : b_oe ? b_frame : 1'b1;
  assign irdy_w = IRDY_N_OE ? IRDY_N_O : b_oe ? b_irdy : 1'b1;
  assign trdy_w = TRDY_N_OE ? TRDY_N_O : t_oe ? t_trdy : 1'b1;
  assign devsel_w = DEVSEL_N_OE ? DEVSEL_N_O : t_oe ? t_dev : 1'b1;
  assign stop_w = t_oe ? t_stop : 1'b1;
  assign ad_w = AD_OE ? AD_O : t_ad_oe ? t_ad : b_ad_oe ? b_ad : flt;
  assign cbe_w = CBE_OE ? CBE_O : b_oe ? b_cbe : flt[3:0];
  assign par_w = PAR_OE ? PAR_O : t_par_oe ? t_par : flt[0];
  pci_bridge dut (.CLK, .RST_N, .FRAME_N_I(frame_w), .FRAME_N_O,
    .FRAME_N_OE, .IRDY_N_I(irdy_w), .IRDY_N_O, .IRDY_N_OE,
    .TRDY_N_I(trdy_w), .TRDY_N_O, .TRDY_N_OE, .DEVSEL_N_I(devsel_w),
    .DEVSEL_N_O, .DEVSEL_N_OE, .STOP_N_I(stop_w), .IDSEL, .GNT_N, .REQ_N,
    .AD_I(ad_w), .AD_O, .AD_OE, .CBE_I(cbe_w), .CBE_O, .CBE_OE,
    .PAR_I(par_w), .PAR_O, .PAR_OE, .BACKEND_MASTER_REQUEST, .WRITE_SEL,
    .IO_SEL, .BURST_IN, .MASTER_ADDR, .MASTER_WDATA, .MASTER_NEXT,
    .MASTER_RDATA, .BACKEND_MASTER_DONE, .RETRY_OUT, .TARGET_ABORT,
    .MASTER_ABORT, .PARITY_ERROR, .CFG_READ_STROBE, .CFG_WRITE_STROBE,
    .CFG_DONE_IN, .CFG_RDATA, .CFG_ADDR, .CFG_WDATA);
  bus_target tgt (.clk(CLK), .rst_n(RST_N), .frame_n(frame_w),
    .irdy_n(irdy_w), .ad(ad_w), .cbe(cbe_w), .mode(mode), .ctl_oe(t_oe),
    .devsel_n(t_dev), .trdy_n(t_trdy), .stop_n(t_stop), .ad_oe(t_ad_oe),
    .ad_o(t_ad), .par_oe(t_par_oe), .par_o(t_par));
  // Clock, float pattern and arbiter grant
  always #25 CLK = ~CLK;
  always @(posedge CLK)
  begin
    flt <= ~flt;
    GNT_N <= REQ_N;
  end
  // Back end presents the next word at each master transfer edge
  always @(posedge CLK)
    if (IRDY_N_OE && !irdy_w && !trdy_w)
    begin
      xf <= xf + 1;
      MASTER_WDATA <= W + xf + 1;
      BURST_IN <= xf + 2 < mn;
    end
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Control lines must be high in the cycle before floating
  always @(negedge CLK)
  begin
    for (int i = 0; i < 4; i++)
      if (RST_N && poe[i] && !{FRAME_N_OE, IRDY_N_OE, TRDY_N_OE,
          DEVSEL_N_OE}[i])
        check("park high", po[i], 1);
    poe = {FRAME_N_OE, IRDY_N_OE, TRDY_N_OE, DEVSEL_N_OE};
    po = {FRAME_N_O, IRDY_N_O, TRDY_N_O, DEVSEL_N_O};
  end
  // One master access with the target in mode md
  task automatic master(input logic wr, io, input int n,
    input logic [2:0] md);
    logic [3:0] cmd;
    logic ok, ep, pchk = 0, f = 0, perr = 0, d = 0;
    logic [2:0] flg = 0;
    int nx = 0, t0 = 0, dt = 0;
    cmd = io ? (wr ? `CMD_IO_WRITE : `CMD_IO_READ)
             : (wr ? `CMD_MEM_WRITE : `CMD_MEM_READ);
    ok = md == 3'h0 || md == 3'h4 || md == 3'h5;
    @(posedge CLK);
    mode <= md;
    {xf, mn} <= {32'd0, n};
    WRITE_SEL <= wr;
    IO_SEL <= io;
    MASTER_WDATA <= W;
    BURST_IN <= n > 1;
    BACKEND_MASTER_REQUEST <= 1'b1;
    for (int t = 0; t < 40; t++)
    begin
      @(negedge CLK);
      if (pchk) check("addr parity", PAR_O, ep);
      pchk = 0;
      if (!f && FRAME_N_OE && !FRAME_N_O)
      begin
        {f, pchk, t0} = {2'b11, t};
        ep = ^{AD_O, CBE_O};
        check("address", AD_O, A);
        check("command", CBE_O, cmd);
      end
      perr |= PARITY_ERROR;
      if (MASTER_NEXT)
      begin
        if (!wr) check("read word", MASTER_RDATA, RB + nx);
        nx++;
      end
      if (BACKEND_MASTER_DONE)
      begin
        {d, dt} = {1'b1, t - t0};
        flg = {RETRY_OUT, TARGET_ABORT, MASTER_ABORT};
        @(posedge CLK);
        BACKEND_MASTER_REQUEST <= 1'b0;
        break;
      end
    end
    repeat (3) @(negedge CLK) perr |= PARITY_ERROR;
    check("done", d, 1);
    check("words", nx, ok ? n : 0);
    check("target words", tgt.wcount, ok ? n : 0);
    check("retry", flg[2], md == 3'h1);
    check("target abort", flg[1], md == 3'h2);
    check("master abort", flg[0], md == 3'h3);
    check("parity error", perr, md == 3'h5 && !wr);
    if (md == 3'h3) check("abort span", dt inside {[5:8]}, 1);
    for (int i = 0; i < n; i++)
      if (wr && ok) check("write word", tgt.wlog[i], W + i);
  endtask
  // Config access from the bench as initiator
  task automatic cfg(input logic wr, pend);
    logic s = 0, hit = 0;
    @(posedge CLK);
    {b_oe, b_frame, b_ad_oe, IDSEL} <= 4'b1011;
    b_ad <= CA;
    b_cbe <= {`CMD_CFG_HI, wr};
    CFG_RDATA <= CD;
    @(posedge CLK);
    {b_frame, b_irdy, b_ad_oe, IDSEL} <= {2'b10, wr, 1'b0};
    b_cbe <= `BE_ALL;
    b_ad <= CD;
    BACKEND_MASTER_REQUEST <= pend;
    for (int t = 0; t < 30 && !hit; t++)
    begin
      @(negedge CLK);
      check("no master", FRAME_N_OE, 0);
      if (!s && (CFG_READ_STROBE || CFG_WRITE_STROBE))
      begin
        s = 1;
        check("strobes", {CFG_WRITE_STROBE, CFG_READ_STROBE},
          wr ? 2 : 1);
        check("cfg addr", CFG_ADDR, CA);
        @(posedge CLK);
        {CFG_DONE_IN, BACKEND_MASTER_REQUEST} <= 2'b10;
        @(posedge CLK);
        CFG_DONE_IN <= 1'b0;
      end
      else if (TRDY_N_OE && !TRDY_N_O)
      begin
        hit = 1;
        check("cfg word", wr ? CFG_WDATA : AD_O, CD);
        @(posedge CLK);
        b_irdy <= 1'b1;
        @(posedge CLK);
        {b_oe, b_ad_oe} <= 2'b00;
      end
    end
    @(negedge CLK);
    check("cfg ended", {hit, s, CFG_READ_STROBE, CFG_WRITE_STROBE},
      4'hc);
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    @(negedge CLK);
    check("floated", {FRAME_N_OE, IRDY_N_OE, TRDY_N_OE, DEVSEL_N_OE,
      AD_OE, CBE_OE, PAR_OE}, 0);
    check("quiet", {BACKEND_MASTER_DONE, RETRY_OUT, TARGET_ABORT,
      MASTER_ABORT, MASTER_NEXT, PARITY_ERROR, CFG_READ_STROBE,
      CFG_WRITE_STROBE, REQ_N}, 1);
    master(1, 0, 1, 3'h0);
    master(0, 1, 1, 3'h4);
    master(1, 1, 3, 3'h0);
    master(0, 0, 3, 3'h4);
    master(0, 0, 1, 3'h1);
    master(1, 0, 1, 3'h2);
    master(1, 1, 1, 3'h3);
    master(0, 1, 1, 3'h5);
    cfg(0, 0);
    cfg(1, 1);
    master(1, 0, 2, 3'h0);
    stop_test;
  end
  // Watchdog against a hang
  initial
  begin
    #(50 * 3000);
    bad_count++;
    stop_test;
  end
endmodule
